//--- pwm_seq_defs.vh
/*
  constants for the multiphase pwm sequencer: register offsets, field
  positions, reset values and timing counts.
  assumes a 20 MHz system clock and a 32-bit ahb-lite register bus.
*/
`ifndef PWM_SEQ_DEFS_VH
`define PWM_SEQ_DEFS_VH

// register byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_REF 8'h08
`define REG_PERIOD 8'h0c
`define REG_SSDIV 8'h10
`define REG_HICCUP 8'h14

// control register fields
`define CTRL_RUN_BIT 0
`define CTRL_OV_BIT 1
`define CTRL_UV_BIT 2
`define CTRL_INWIN_BIT 3
`define CTRL_HOT_BIT 4
`define CTRL_FAN_BIT 5

// status register fields
`define ST_RUN_BIT 0
`define ST_SSDONE_BIT 1
`define ST_OVLATCH_BIT 2
`define ST_OCLATCH_BIT 3
`define ST_READY_BIT 4
`define ST_NPH_LSB 8

// reset values
`define PERIOD_RESET 16'h0078
`define SSDIV_RESET 16'h0014
`define HICCUP_RESET 16'h1000

// soft-start figures: one code step is 6.25 mV, 1.1 V is step 176
`define STEP_UV 6250
`define BOOT_UV 1100000
`define BOOT_STEPS 8'hb0

`endif

//--- phase_sequencer.v
/*
  phase_sequencer: cycles a one-hot pulse around the active phases in the
  firing order that the phase count selects.
  assumes a synchronous active-low reset and a level run enable.
*/
`timescale 1ns/1ns
module phase_sequencer #(
  parameter PW = 16
) (
  input wire mclk,
  input wire rstSyncB,
  input wire runEn,
  input wire [2:0] numPhases,
  input wire [PW-1:0] periodSlot,
  output reg [5:0] phaseDrive
);
  reg [PW-1:0] slotCnt_reg; // cycles within one phase slot
  reg [2:0] slotIdx_reg; // position in the firing order

  // maps order position to drive bit; four phases swap 3 and 4
  function [5:0] orderMap;
    input [2:0] n;
    input [2:0] pos;
    begin
      orderMap = 6'h01 << pos;
      if (n == 3'd4 && pos == 3'd2)
        orderMap = 6'h08;
      else if (n == 3'd4 && pos == 3'd3)
        orderMap = 6'h04;
    end
  endfunction

  // slot timer and order index; all off while stopped
  always @(posedge mclk) begin
    if (!rstSyncB || !runEn) begin
      slotCnt_reg <= {PW{1'b0}};
      slotIdx_reg <= 3'd0;
      phaseDrive <= 6'h00;
    end else begin
      phaseDrive <= orderMap(numPhases, slotIdx_reg);
      if (slotCnt_reg >= periodSlot) begin
        slotCnt_reg <= {PW{1'b0}};
        if (slotIdx_reg >= numPhases - 3'd1)
          slotIdx_reg <= 3'd0;
        else
          slotIdx_reg <= slotIdx_reg + 3'd1;
      end else begin
        slotCnt_reg <= slotCnt_reg + {{(PW-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule

//--- multiphase_pwm_sequencer.v
/*
  multiphase_pwm_sequencer: enable gating, fault supervision, voltage code
  decoding, soft-start reference ramp and phase firing, with an ahb-lite
  register slave. analog comparisons arrive as synchronous level inputs.
  assumes a single 20 MHz clock mclk and active-low asynchronous rst_b.
*/
`timescale 1ns/1ns
`include "pwm_seq_defs.vh"
module multiphase_pwm_sequencer #(
  parameter PW = 16
) (
  input wire mclk,
  input wire rst_b,
  input wire powerGood, // supply above power-on threshold
  input wire powerEnableHigh, // power_enable_in above 0.875V
  input wire powerEnableLow, // power_enable_in below 0.745V
  input wire termEnableHigh, // termination_enable_in above 0.875V
  input wire termEnableLow, // termination_enable_in below 0.745V
  input wire [7:0] voltage_code_in,
  input wire code_table_select,
  input wire [5:0] phaseStrapIn, // drive pins read back as strapped high
  input wire overVoltage, // sensed output above limit
  input wire underVoltage, // sensed output below limit
  input wire inWindow, // sensed output inside regulation window
  input wire overcurrent_trip, // load_current_monitor above 2V
  input wire tempAlarm, // temperature_sense_in at alarm level
  input wire tempFan, // temperature_sense_in at fan level
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire [31:0] hrdata,
  output wire hreadyout,
  output wire hresp,
  output wire [5:0] phase_drive_out,
  output wire [5:0] phaseDriveOe, // low on strapped pins
  output reg [7:0] internal_reference,
  output wire regulatorReadyOe, // high pulls regulator_ready low
  output reg overvoltage_flag_out,
  output wire thermalAlarmOe, // high pulls thermal_alarm low
  output wire fanRequestOe // high pulls fan_request low
);
  localparam ST_OFF = 2'd0;
  localparam ST_SOFT = 2'd1;
  localparam ST_RUN = 2'd2;
  localparam ST_HICCUP = 2'd3;

  reg rstMeta_reg; // first reset synchroniser stage
  reg rstSyncB; // released reset copy
  reg [1:0] state_reg; // sequencer state
  reg [1:0] state_next;
  reg ovLatch_reg; // latched overvoltage fault
  reg ocLatch_reg; // latched overcurrent fault
  reg ready_reg; // regulator ready level
  reg [15:0] ssDivCnt_reg; // soft-start oscillator divider
  reg [15:0] hiccupCnt_reg; // hiccup wait counter
  reg [31:0] ctrl_reg; // software control word
  reg [15:0] period_reg; // cycles per phase slot
  reg [15:0] ssDiv_reg; // cycles per soft-start step
  reg [15:0] hiccup_reg; // hiccup off time in cycles
  reg [7:0] strap_reg; // phase count captured after reset
  reg strapDone_reg; // strap captured once
  reg [7:0] target_reg; // decoded target reference
  reg [31:0] rdData_reg; // read data register
  reg dpWrite_reg; // data phase is a write
  reg [7:0] dpAddr_reg; // data phase address
  reg ssTick; // one-cycle soft-start step
  reg [2:0] numPhases; // active phase count
  wire enablesOn; // both enables above high threshold and power good
  wire enableDrop; // either enable below low threshold
  wire runEn; // phases may fire
  wire ctrlRun; // software run permission
  wire busTake; // address phase accepted
  wire [5:0] seqDrive;

  assign ctrlRun = ctrl_reg[`CTRL_RUN_BIT];
  assign enablesOn = powerEnableHigh && termEnableHigh && powerGood;
  assign enableDrop = powerEnableLow || termEnableLow;
  assign runEn = (state_reg == ST_SOFT || state_reg == ST_RUN);

  // two-stage reset release
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_reg <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSyncB <= rstMeta_reg;
    end
  end

  // decodes a code to reference steps; legacy table is inverted, the other offset by two
  function [7:0] codeDecode;
    input [7:0] code;
    input legacy;
    begin
      if (legacy)
        codeDecode = 8'hff - code;
      else if (code < 8'h02)
        codeDecode = 8'h00; // off codes
      else
        codeDecode = code - 8'h02;
    end
  endfunction

  // phase count from the lowest strapped pin; all free gives six
  always @* begin
    if (phaseStrapIn[2])
      numPhases = 3'd2;
    else if (phaseStrapIn[3])
      numPhases = 3'd3;
    else if (phaseStrapIn[4])
      numPhases = 3'd4;
    else if (phaseStrapIn[5])
      numPhases = 3'd5;
    else
      numPhases = 3'd6;
  end

  // catch the strap once after reset release, while drivers are off
  always @(posedge mclk) begin
    if (!rstSyncB) begin
      strap_reg <= 8'h06;
      strapDone_reg <= 1'b0;
    end else if (!strapDone_reg) begin
      strap_reg <= {5'h00, numPhases};
      strapDone_reg <= 1'b1;
    end
  end

  // target reference; undriven pins read one from the pull-ups
  always @(posedge mclk) begin
    if (!rstSyncB)
      target_reg <= 8'h00;
    else
      target_reg <= codeDecode(voltage_code_in, !code_table_select);
  end

  // soft-start oscillator divider
  always @(posedge mclk) begin
    if (!rstSyncB || state_reg != ST_SOFT) begin
      ssDivCnt_reg <= 16'h0000;
      ssTick <= 1'b0;
    end else if (ssDivCnt_reg >= ssDiv_reg) begin
      ssDivCnt_reg <= 16'h0000;
      ssTick <= 1'b1;
    end else begin
      ssDivCnt_reg <= ssDivCnt_reg + 16'h0001;
      ssTick <= 1'b0;
    end
  end

  // state transitions
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (enablesOn && ctrlRun && !ovLatch_reg && !ocLatch_reg)
          state_next = ST_SOFT;
      end
      ST_SOFT: begin
        if (!enablesOn || !ctrlRun || ovLatch_reg)
          state_next = ST_OFF;
        else if (overcurrent_trip)
          state_next = ST_HICCUP;
        else if (internal_reference == target_reg && internal_reference >= `BOOT_STEPS)
          state_next = ST_RUN;
      end
      ST_RUN: begin
        if (!enablesOn || !ctrlRun || ovLatch_reg)
          state_next = ST_OFF;
        else if (overcurrent_trip)
          state_next = ST_HICCUP;
      end
      ST_HICCUP: begin
        if (!enablesOn || enableDrop)
          state_next = ST_OFF;
        else if (hiccupCnt_reg >= hiccup_reg)
          state_next = ST_SOFT;
      end
      default: state_next = ST_OFF;
    endcase
  end

  // state, reference ramp, faults and ready
  always @(posedge mclk) begin
    if (!rstSyncB || !powerGood) begin
      state_reg <= ST_OFF;
      internal_reference <= 8'h00;
      ovLatch_reg <= 1'b0;
      ocLatch_reg <= 1'b0;
      overvoltage_flag_out <= 1'b0;
      hiccupCnt_reg <= 16'h0000;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (overVoltage) begin
        ovLatch_reg <= 1'b1;
        overvoltage_flag_out <= 1'b1;
      end else if (enableDrop) begin
        ovLatch_reg <= 1'b0;
        overvoltage_flag_out <= 1'b0;
      end
      if (overcurrent_trip && runEn)
        ocLatch_reg <= 1'b1;
      else if (enableDrop || state_reg == ST_SOFT)
        ocLatch_reg <= 1'b0;
      if (state_reg == ST_HICCUP)
        hiccupCnt_reg <= hiccupCnt_reg + 16'h0001;
      else
        hiccupCnt_reg <= 16'h0000;
      if (state_reg == ST_OFF || state_reg == ST_HICCUP)
        internal_reference <= 8'h00;
      else if (ssTick && state_reg == ST_SOFT) begin
        if (internal_reference < `BOOT_STEPS)
          internal_reference <= internal_reference + 8'h01;
        else if (internal_reference < target_reg)
          internal_reference <= internal_reference + 8'h01;
        else if (internal_reference > target_reg)
          internal_reference <= internal_reference - 8'h01;
      end else if (state_reg == ST_RUN)
        internal_reference <= target_reg;
      ready_reg <= (state_reg == ST_RUN) && inWindow && !underVoltage
                   && !overVoltage && !overcurrent_trip && !ovLatch_reg;
    end
  end

  phase_sequencer #(
    .PW(PW)
  ) u_seq (
    .mclk(mclk),
    .rstSyncB(rstSyncB),
    .runEn(runEn),
    .numPhases(strap_reg[2:0]),
    .periodSlot(period_reg[PW-1:0]),
    .phaseDrive(seqDrive)
  );

  // strapped pins are not driven; active pins follow the sequencer
  assign phase_drive_out = seqDrive;
  assign phaseDriveOe = ~phaseStrapIn;
  assign regulatorReadyOe = !ready_reg;
  assign thermalAlarmOe = !tempAlarm;
  assign fanRequestOe = !tempFan;

  // ahb-lite slave: zero wait states, always okay
  assign busTake = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdData_reg;

  always @(posedge mclk) begin
    if (!rstSyncB) begin
      dpWrite_reg <= 1'b0;
      dpAddr_reg <= 8'h00;
      rdData_reg <= 32'h00000000;
      ctrl_reg <= 32'h00000001;
      period_reg <= `PERIOD_RESET;
      ssDiv_reg <= `SSDIV_RESET;
      hiccup_reg <= `HICCUP_RESET;
    end else begin
      dpWrite_reg <= busTake && hwrite;
      dpAddr_reg <= haddr[7:0];
      if (dpWrite_reg) begin
        case (dpAddr_reg)
          `REG_CTRL: ctrl_reg <= {31'h00000000, hwdata[0]};
          `REG_PERIOD: period_reg <= hwdata[15:0];
          `REG_SSDIV: ssDiv_reg <= hwdata[15:0];
          `REG_HICCUP: hiccup_reg <= hwdata[15:0];
          default: ctrl_reg <= ctrl_reg;
        endcase
      end
      if (busTake && !hwrite) begin
        case (haddr[7:0])
          `REG_CTRL: rdData_reg <= ctrl_reg;
          `REG_STATUS: rdData_reg <= {21'h000000, strap_reg[2:0], 3'h0, ready_reg,
                                      ocLatch_reg, ovLatch_reg, (state_reg == ST_RUN),
                                      runEn};
          `REG_REF: rdData_reg <= {16'h0000, target_reg, internal_reference};
          `REG_PERIOD: rdData_reg <= {16'h0000, period_reg};
          `REG_SSDIV: rdData_reg <= {16'h0000, ssDiv_reg};
          `REG_HICCUP: rdData_reg <= {16'h0000, hiccup_reg};
          default: rdData_reg <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

//--- mps_chk.sv
/* port assertions for the multiphase pwm sequencer.
   assumes it is bound into the top module and sees its ports by name. */
`timescale 1ns/1ns
module mps_chk (
  input wire mclk,
  input wire rst_b,
  input wire powerGood,
  input wire powerEnableHigh,
  input wire powerEnableLow,
  input wire termEnableHigh,
  input wire termEnableLow,
  input wire overVoltage,
  input wire underVoltage,
  input wire overcurrent_trip,
  input wire tempAlarm,
  input wire tempFan,
  input wire [5:0] phaseStrapIn,
  input wire [5:0] phase_drive_out,
  input wire [5:0] phaseDriveOe,
  input wire [7:0] internal_reference,
  input wire regulatorReadyOe,
  input wire overvoltage_flag_out,
  input wire thermalAlarmOe,
  input wire fanRequestOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // strapped pins are left alone by the sequencer
  AST_STRAP: assert property (phaseDriveOe == ~phaseStrapIn
    && (phase_drive_out & phaseStrapIn) == 6'h00) else $error("strapped pin driven");
  AST_ONEHOT: assert property ($onehot0(phase_drive_out)) else $error("two phases on");
  AST_ORD12: assert property ($past(phase_drive_out) == 6'h01 && !phase_drive_out[0]
    && phase_drive_out != 6'h00 |-> phase_drive_out[1]) else $error("phase two not next");
  AST_ORD4: assert property (phaseStrapIn == 6'h10 && $past(phase_drive_out) == 6'h02
    && phase_drive_out != 6'h02 && phase_drive_out != 6'h00 |-> phase_drive_out == 6'h08)
    else $error("four-phase order wrong");
  AST_OFF: assert property (!powerGood || !powerEnableHigh || !termEnableHigh
    |-> ##[1:3] phase_drive_out == 6'h00) else $error("drive while disabled");
  AST_OC: assert property (overcurrent_trip |-> ##[1:3] phase_drive_out == 6'h00
    && regulatorReadyOe) else $error("overcurrent not acted on");
  AST_RDY: assert property (overVoltage || underVoltage |-> ##[1:3] regulatorReadyOe)
    else $error("ready not pulled low");
  AST_OV: assert property (overVoltage |-> ##[1:2] overvoltage_flag_out)
    else $error("overvoltage flag not set");
  // the flag only drops while an enable sits below its clear level or powerGood is low
  AST_OVHOLD: assert property (overvoltage_flag_out && !powerEnableLow && !termEnableLow
    |=> overvoltage_flag_out) else $error("overvoltage flag lost");
  AST_RAMP: assert property (internal_reference > $past(internal_reference)
    |-> internal_reference == $past(internal_reference) + 8'h01) else $error("ramp step");
  AST_THERM: assert property (thermalAlarmOe == !tempAlarm && fanRequestOe == !tempFan)
    else $error("thermal outputs wrong");
endmodule

bind multiphase_pwm_sequencer mps_chk mps_chk_inst (.*);

//--- gate_drv_model.sv
/* far side: the processor code lines and the gate driver inputs.
   assumes released code lines float up to the pull-up level. */
`timescale 1ns/1ns
module gate_drv_model (
  input wire mclk,
  input wire clr,
  input wire codeOe,
  input wire [7:0] codeVal,
  input wire selVal,
  input wire [5:0] drive,
  output tri1 [7:0] codeBus,
  output tri1 selBus
);
  logic [5:0] seen [0:15]; // phases in the order they fired
  logic [5:0] last; // phase seen most recently
  int seenCnt; // entries logged so far
  // released lines read as one through the pull-up
  assign codeBus = codeOe ? codeVal : 8'hzz;
  assign selBus = codeOe ? selVal : 1'bz;
  // log each new phase that switches on, up to 16 entries
  always @(posedge mclk) begin
    if (clr) begin
      seenCnt <= 0;
      last <= 6'h00;
    end else if (drive != 6'h00 && drive != last && seenCnt < 16) begin
      seen[seenCnt] <= drive;
      seenCnt <= seenCnt + 1;
      last <= drive;
    end
  end
endmodule

//--- tb_top.sv
/* self-checking bench for the multiphase pwm sequencer.
   assumes a 20 MHz clock and an ahb-lite master in the bench. */
`timescale 1ns/1ns
`include "pwm_seq_defs.vh"
module tb_top;
  logic mclk, rst_b, powerGood, powerEnableHigh, powerEnableLow, termEnableHigh, termEnableLow;
  logic overVoltage, underVoltage, inWindow, overcurrent_trip, tempAlarm, tempFan;
  logic hsel, hwrite, clr, codeOe, selVal;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, rd;
  logic [5:0] phaseStrapIn;
  logic [7:0] codeVal;
  tri1 [7:0] voltage_code_in;
  tri1 code_table_select;
  wire hreadyout, hresp, regulatorReadyOe, overvoltage_flag_out, thermalAlarmOe, fanRequestOe;
  wire [31:0] hrdata;
  wire [5:0] phase_drive_out, phaseDriveOe;
  wire [7:0] internal_reference;
  wire hready = hreadyout;
  int n_fail, cmp_count;
  localparam logic [5:0] ST [5] = '{6'h00, 6'h20, 6'h10, 6'h08, 6'h04};
  localparam logic [23:0] ORD [5] = '{24'h123456, 24'h12345, 24'h1243, 24'h123, 24'h12};
  multiphase_pwm_sequencer multiphase_pwm_sequencer_inst (.*);
  gate_drv_model gate_drv_model_inst (.mclk(mclk), .clr(clr), .codeOe(codeOe),
    .codeVal(codeVal), .selVal(selVal), .drive(phase_drive_out),
    .codeBus(voltage_code_in), .selBus(code_table_select));
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // cut a hang short
  initial begin
    #2000000;
    n_fail++;
    end_sim;
  end
  task end_sim;
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one single ahb-lite transfer, read data left in rd
  // waits on hready without a limit of its own; the watchdog ends a hang
  task ahb(input logic [31:0] a, input logic w, input logic [31:0] wd);
    haddr <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rst(input logic [5:0] s);
    rst_b <= 1'b0;
    clr <= 1'b1;
    phaseStrapIn <= s;
    repeat (16) @(posedge mclk);
    rst_b <= 1'b1;
    clr <= 1'b0;
    repeat (3) @(posedge mclk);
  endtask
  // reset, then short slots and a fast soft-start
  task boot(input logic [5:0] s);
    rst(s);
    ahb(`REG_PERIOD, 1'b1, 32'h4);
    ahb(`REG_SSDIV, 1'b1, 32'h0);
  endtask
  task wait_run;
    int k;
    k = 0;
    do begin ahb(`REG_STATUS, 1'b0, 32'h0); k++; end while (rd[1] !== 1'b1 && k < 600);
    chk(rd[1], 1'b1);
  endtask
  task t_regs;
    ahb(`REG_CTRL, 1'b0, 32'h0);
    chk(rd[0], 1'b1);
    chk(hresp, 1'b0);
    ahb(`REG_PERIOD, 1'b0, 32'h0);
    chk(rd[15:0], `PERIOD_RESET);
    ahb(`REG_SSDIV, 1'b0, 32'h0);
    chk(rd[15:0], `SSDIV_RESET);
    ahb(`REG_HICCUP, 1'b0, 32'h0);
    chk(rd[15:0], `HICCUP_RESET);
    ahb(32'h40, 1'b1, 32'hffff);
    ahb(32'h40, 1'b0, 32'h0);
    chk(rd, 32'h0);
  endtask
  // every phase count from six down to two: strapped count and firing order
  task t_phases;
    int n;
    for (int i = 0; i < 5; i++) begin
      n = 6 - i;
      boot(ST[i]);
      wait_run;
      ahb(`REG_STATUS, 1'b0, 32'h0);
      chk(rd[10:8], n);
      for (int j = 0; j < 8; j++)
        chk(gate_drv_model_inst.seen[j], 32'h1 << (ORD[i][4*(n-1-j%n) +: 4] - 1));
      repeat (5) @(posedge mclk);
      chk(regulatorReadyOe, 1'b0);
    end
  endtask
  // both tables and released code lines, ready held off outside the window
  task t_code;
    inWindow <= 1'b0;
    boot(6'h00);
    chk(code_table_select, 1'b1);
    ahb(`REG_REF, 1'b0, 32'h0);
    chk(rd[15:8], 8'hc6);
    selVal <= 1'b0;
    codeVal <= 8'h20;
    repeat (8) @(posedge mclk);
    ahb(`REG_REF, 1'b0, 32'h0);
    chk(rd[15:8], 8'hdf);
    codeOe <= 1'b0;
    repeat (8) @(posedge mclk);
    ahb(`REG_REF, 1'b0, 32'h0);
    chk(rd[15:8], 8'hfd);
    wait_run;
    repeat (5) @(posedge mclk);
    chk(internal_reference, 8'hfd);
    chk(regulatorReadyOe, 1'b1);
    inWindow <= 1'b1;
    repeat (5) @(posedge mclk);
    chk(regulatorReadyOe, 1'b0);
    {codeOe, selVal} <= 2'b11;
    codeVal <= 8'h01;
    repeat (8) @(posedge mclk);
    ahb(`REG_REF, 1'b0, 32'h0);
    chk(rd[15:8], 8'h00);
    codeVal <= 8'hc8;
  endtask
  task t_faults;
    int k;
    boot(6'h00);
    ahb(`REG_HICCUP, 1'b1, 32'h40);
    wait_run;
    underVoltage <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(regulatorReadyOe, 1'b1);
    underVoltage <= 1'b0;
    overVoltage <= 1'b1;
    repeat (3) @(posedge mclk);
    overVoltage <= 1'b0;
    repeat (20) @(posedge mclk);
    chk(overvoltage_flag_out, 1'b1);
    chk(regulatorReadyOe, 1'b1);
    {powerEnableHigh, powerEnableLow} <= 2'b01;
    repeat (5) @(posedge mclk);
    chk(phase_drive_out, 6'h00);
    chk(overvoltage_flag_out, 1'b0);
    {powerEnableHigh, powerEnableLow} <= 2'b10;
    ahb(`REG_STATUS, 1'b0, 32'h0);
    chk(rd[1], 1'b0);
    wait_run;
    overcurrent_trip <= 1'b1;
    repeat (3) @(posedge mclk);
    overcurrent_trip <= 1'b0;
    chk(phase_drive_out, 6'h00);
    ahb(`REG_STATUS, 1'b0, 32'h0);
    chk(rd[3], 1'b1);
    k = 0;
    do begin @(posedge mclk); k++; end while (phase_drive_out === 6'h00 && k < 400);
    chk(phase_drive_out !== 6'h00, 1'b1);
  endtask
  task t_misc;
    termEnableHigh <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(phase_drive_out, 6'h00);
    termEnableHigh <= 1'b1;
    powerGood <= 1'b0;
    repeat (4) @(posedge mclk);
    chk(phase_drive_out, 6'h00);
    powerGood <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      {tempAlarm, tempFan} <= i[1:0];
      repeat (2) @(posedge mclk);
      chk({thermalAlarmOe, fanRequestOe}, 2'b11 ^ i[1:0]);
    end
  endtask
  initial begin
    {powerGood, powerEnableHigh, termEnableHigh, inWindow, hsel, codeOe, selVal} = 7'h7f;
    {powerEnableLow, termEnableLow, overVoltage, underVoltage, overcurrent_trip} = 5'h00;
    {tempAlarm, tempFan, hwrite, clr, rst_b} = 5'h00;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0;
    hwdata = 32'h0;
    phaseStrapIn = 6'h00;
    codeVal = 8'hc8;
    n_fail = 0;
    cmp_count = 0;
    rst(6'h00);
    t_regs;
    t_phases;
    t_code;
    t_faults;
    t_misc;
    end_sim;
  end
endmodule
